//--- cduo_top.sv
/*
 * Per-channel DMA error handler: transmit underflow and receive overflow
 * detection, channel suspension, data discard and interrupt descriptor
 * posting. Assumes the DMA side runs on mclk_i and the serial link clock
 * and receive data arrive as pins sampled by mclk_i.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - Empty FIFO with host-owned next buffer after data was sent posts host-owned error, direction 1.
// - After that error, stop fetching and suspend transmit.
// - No buffer status write-back after any transmit underflow.
// - No bus transfers for a suspended direction until reactivated.
// - Under-run is FIFO empty at a bit instant while owning a buffer.
// - Under-run posts FIFO-run error, direction 1.
// - After under-run the channel sends idle code continuously.
// - After under-run stop reading data and suspend until reactivated.
// - That overflow discards the FIFO contents, never delivered.
// - That overflow deactivates receive; host reactivates it.
// - Overrun is a byte to store while the FIFO is full, buffer held.
// - Receive overrun posts FIFO-run error, direction 0.
// - Receive overrun discards the FIFO contents.
// - Receive overrun suspends receive until reactivated.
// - Receive resumes on activate, jump or configuration write.
// - Transparent mode empty FIFO with host buffer raises host-owned error, idles.
module cduo_top #(parameter int TX_DEPTH = cduo_pkg::FIFO_DEPTH,
                  parameter int RX_DEPTH = cduo_pkg::FIFO_DEPTH)
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    input wire logic rxd_i,
    output logic txd_o,
    input wire logic transparent_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic tx_buf_owned_i,
    input wire logic tx_react_i,
    output logic tx_wb_en_o,
    output logic tx_susp_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    input wire logic rx_buf_owned_i,
    input wire logic rx_act_i,
    input wire logic rx_jump_i,
    input wire logic rx_cfg_wr_i,
    output logic rx_susp_o,
    output logic intd_valid_o,
    output logic [1:0] intd_err_o,
    output logic intd_dir_o
);

    // ------------------------------------------------------------
    // Pin synchronisation and link clock edges
    // ------------------------------------------------------------
    logic [cduo_pkg::PIN_COUNT-1:0] pin_s;
    logic sclk_s;
    logic rxd_s;
    logic sclk_d_r;
    logic srise;
    logic sfall;

    cduo_sync #(.W(cduo_pkg::PIN_COUNT)) u_sync (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .d_i({sclk_i, rxd_i}),
        .q_o(pin_s)
    );

    assign sclk_s = pin_s[1];
    assign rxd_s = pin_s[0];
    assign srise = sclk_s && !sclk_d_r;
    assign sfall = !sclk_s && sclk_d_r;

    // ------------------------------------------------------------
    // Internal FIFOs
    // ------------------------------------------------------------
    cduo_fifo_if #(.W(cduo_pkg::BYTE_W)) txf ();
    cduo_fifo_if #(.W(cduo_pkg::BYTE_W)) rxf ();

    cduo_fifo #(.W(cduo_pkg::BYTE_W), .DEPTH(TX_DEPTH)) u_txf (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .f(txf.store)
    );

    cduo_fifo #(.W(cduo_pkg::BYTE_W), .DEPTH(RX_DEPTH)) u_rxf (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .f(rxf.store)
    );

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    logic [7:0] tx_sh_r;
    logic [7:0] tx_sh_nxt;
    logic [2:0] tx_cnt_r;
    logic [2:0] tx_cnt_nxt;
    logic txd_r;
    logic txd_nxt;
    logic tx_susp_r;
    logic tx_susp_nxt;
    logic tx_busy_r;
    logic tx_busy_nxt;
    logic tx_ready_r;
    logic tx_ready_nxt;
    logic tx_wb_en_r;
    logic tx_wb_en_nxt;
    logic tx_err_host;
    logic tx_err_fifo;
    logic tx_err;

    // Fetched words enter the FIFO only while fetching is allowed
    assign txf.push = tx_valid_i && tx_ready_r;
    assign txf.wdata = tx_data_i;
    assign txf.flush = 1'h0;
    assign tx_err = tx_err_host || tx_err_fifo;

    // Bit output, under-run detection and suspension
    always_comb
    begin
        tx_sh_nxt = tx_sh_r;
        tx_cnt_nxt = tx_cnt_r;
        txd_nxt = txd_r;
        tx_susp_nxt = tx_susp_r;
        tx_busy_nxt = tx_busy_r;
        txf.pop = 1'h0;
        tx_err_host = 1'h0;
        tx_err_fifo = 1'h0;
        if (sfall && tx_cnt_r == cduo_pkg::BIT_NONE)
        begin
            if (!tx_susp_r && !txf.empty)
            begin
                txf.pop = 1'h1;
                txd_nxt = txf.rdata[cduo_pkg::BYTE_MSB];
                tx_sh_nxt = {txf.rdata[cduo_pkg::BYTE_MSB-1:0], 1'h0};
                tx_busy_nxt = 1'h1;
            end
            else
            begin
                // Empty at a bit instant: classify by buffer ownership
                if (!tx_susp_r && tx_buf_owned_i)
                    tx_err_fifo = 1'h1;
                else if (!tx_susp_r && (tx_busy_r || transparent_i))
                    tx_err_host = 1'h1;
                txd_nxt = cduo_pkg::IDLE_CODE[cduo_pkg::BYTE_MSB];
                tx_sh_nxt = {cduo_pkg::IDLE_CODE[cduo_pkg::BYTE_MSB-1:0], 1'h0};
            end
            tx_cnt_nxt = cduo_pkg::BIT_LAST;
        end
        else if (sfall)
        begin
            txd_nxt = tx_sh_r[cduo_pkg::BYTE_MSB];
            tx_sh_nxt = {tx_sh_r[cduo_pkg::BYTE_MSB-1:0], 1'h0};
            tx_cnt_nxt = tx_cnt_r - cduo_pkg::BIT_STEP;
        end
        // Error suspends; a reactivation in the same cycle loses
        if (tx_err_host || tx_err_fifo)
        begin
            tx_susp_nxt = 1'h1;
            tx_busy_nxt = 1'h0;
        end
        else if (tx_react_i)
            tx_susp_nxt = 1'h0;
        tx_ready_nxt = !tx_susp_nxt && !txf.afull && !txf.full;
        tx_wb_en_nxt = !tx_susp_nxt;
    end

    // Transmit registers
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            tx_sh_r <= cduo_pkg::IDLE_CODE;
            tx_cnt_r <= cduo_pkg::BIT_NONE;
            txd_r <= cduo_pkg::IDLE_CODE[cduo_pkg::BYTE_MSB];
            tx_susp_r <= 1'h0;
            tx_busy_r <= 1'h0;
            tx_ready_r <= 1'h0;
            tx_wb_en_r <= 1'h1;
            sclk_d_r <= 1'h0;
        end
        else
        begin
            tx_sh_r <= tx_sh_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            txd_r <= txd_nxt;
            tx_susp_r <= tx_susp_nxt;
            tx_busy_r <= tx_busy_nxt;
            tx_ready_r <= tx_ready_nxt;
            tx_wb_en_r <= tx_wb_en_nxt;
            sclk_d_r <= sclk_s;
        end
    end

    // ------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------
    logic [7:0] rx_sh_r;
    logic [7:0] rx_sh_nxt;
    logic [2:0] rx_cnt_r;
    logic [2:0] rx_cnt_nxt;
    logic rx_susp_r;
    logic rx_susp_nxt;
    logic rx_valid_r;
    logic rx_valid_nxt;
    logic [7:0] rx_data_r;
    logic [7:0] rx_data_nxt;
    logic rx_err_host;
    logic rx_err_fifo;
    logic rx_err;
    logic rx_react;

    assign rxf.wdata = {rx_sh_r[cduo_pkg::BYTE_MSB-1:0], rxd_s};
    assign rx_err = rx_err_host || rx_err_fifo;
    assign rx_react = rx_act_i || rx_jump_i || rx_cfg_wr_i;

    // Bit capture, overflow detection, discard and drain
    always_comb
    begin
        rx_sh_nxt = rx_sh_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_susp_nxt = rx_susp_r;
        rx_valid_nxt = rx_valid_r;
        rx_data_nxt = rx_data_r;
        rxf.push = 1'h0;
        rxf.pop = 1'h0;
        rxf.flush = 1'h0;
        rx_err_host = 1'h0;
        rx_err_fifo = 1'h0;
        if (srise && !rx_susp_r)
        begin
            rx_sh_nxt = {rx_sh_r[cduo_pkg::BYTE_MSB-1:0], rxd_s};
            rx_cnt_nxt = rx_cnt_r + cduo_pkg::BIT_STEP;
            if (rx_cnt_r == cduo_pkg::BIT_LAST)
            begin
                // A whole byte must be stored now
                if (rxf.full && rx_buf_owned_i)
                    rx_err_fifo = 1'h1;
                else if (rxf.full)
                    rx_err_host = 1'h1;
                else
                    rxf.push = 1'h1;
            end
        end
        if (rx_err_host || rx_err_fifo)
        begin
            rx_susp_nxt = 1'h1;
            rxf.flush = 1'h1;
            rx_cnt_nxt = cduo_pkg::BIT_NONE;
        end
        else if (rx_react)
        begin
            rx_susp_nxt = 1'h0;
            rx_cnt_nxt = cduo_pkg::BIT_NONE;
        end
        // Output stage toward shared memory
        if (rx_err_host || rx_err_fifo)
            rx_valid_nxt = 1'h0;
        else if (!rx_susp_r && (!rx_valid_r || rx_ready_i))
        begin
            rx_valid_nxt = !rxf.empty;
            rxf.pop = !rxf.empty;
            rx_data_nxt = rxf.empty ? rx_data_r : rxf.rdata;
        end
    end

    // Receive registers
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            rx_sh_r <= '0;
            rx_cnt_r <= cduo_pkg::BIT_NONE;
            rx_susp_r <= 1'h0;
            rx_valid_r <= 1'h0;
            rx_data_r <= '0;
        end
        else
        begin
            rx_sh_r <= rx_sh_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_susp_r <= rx_susp_nxt;
            rx_valid_r <= rx_valid_nxt;
            rx_data_r <= rx_data_nxt;
        end
    end

    // ------------------------------------------------------------
    // Interrupt descriptor posting
    // ------------------------------------------------------------
    logic tx_pend_r;
    logic tx_pend_nxt;
    logic rx_pend_r;
    logic rx_pend_nxt;
    logic [1:0] tx_code_r;
    logic [1:0] tx_code_nxt;
    logic [1:0] rx_code_r;
    logic [1:0] rx_code_nxt;
    logic int_valid_r;
    logic int_valid_nxt;
    logic [1:0] int_err_r;
    logic [1:0] int_err_nxt;
    logic int_dir_r;
    logic int_dir_nxt;

    // Pending errors queue one descriptor each; transmit goes first
    always_comb
    begin
        tx_pend_nxt = tx_pend_r || tx_err;
        rx_pend_nxt = rx_pend_r || rx_err;
        tx_code_nxt = tx_code_r;
        rx_code_nxt = rx_code_r;
        if (tx_err)
            tx_code_nxt = tx_err_host ? cduo_pkg::ERR_HOST_OWNED
                                     : cduo_pkg::ERR_FIFO_RUN;
        if (rx_err)
            rx_code_nxt = rx_err_host ? cduo_pkg::ERR_HOST_OWNED
                                     : cduo_pkg::ERR_FIFO_RUN;
        int_valid_nxt = 1'h0;
        int_err_nxt = int_err_r;
        int_dir_nxt = int_dir_r;
        if (tx_pend_r)
        begin
            int_valid_nxt = 1'h1;
            int_err_nxt = tx_code_r;
            int_dir_nxt = cduo_pkg::DIR_TX;
            tx_pend_nxt = tx_err;
        end
        else if (rx_pend_r)
        begin
            int_valid_nxt = 1'h1;
            int_err_nxt = rx_code_r;
            int_dir_nxt = cduo_pkg::DIR_RX;
            rx_pend_nxt = rx_err;
        end
    end

    // Descriptor registers
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            tx_pend_r <= 1'h0;
            rx_pend_r <= 1'h0;
            tx_code_r <= cduo_pkg::ERR_NONE;
            rx_code_r <= cduo_pkg::ERR_NONE;
            int_valid_r <= 1'h0;
            int_err_r <= cduo_pkg::ERR_NONE;
            int_dir_r <= cduo_pkg::DIR_RX;
        end
        else
        begin
            tx_pend_r <= tx_pend_nxt;
            rx_pend_r <= rx_pend_nxt;
            tx_code_r <= tx_code_nxt;
            rx_code_r <= rx_code_nxt;
            int_valid_r <= int_valid_nxt;
            int_err_r <= int_err_nxt;
            int_dir_r <= int_dir_nxt;
        end
    end

    // Outputs straight from flops
    assign txd_o = txd_r;
    assign tx_ready_o = tx_ready_r;
    assign tx_wb_en_o = tx_wb_en_r;
    assign tx_susp_o = tx_susp_r;
    assign rx_data_o = rx_data_r;
    assign rx_valid_o = rx_valid_r;
    assign rx_susp_o = rx_susp_r;
    assign intd_valid_o = int_valid_r;
    assign intd_err_o = int_err_r;
    assign intd_dir_o = int_dir_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_tx_host_post;
        ##2 (intd_valid_o && intd_dir_o && intd_err_o == cduo_pkg::ERR_HOST_OWNED);
    endsequence

    sequence s_tx_fifo_post;
        ##2 (intd_valid_o && intd_dir_o && intd_err_o == cduo_pkg::ERR_FIFO_RUN);
    endsequence

    a_tx_host_post: assert property (tx_err_host |-> s_tx_host_post)
        else $error("transmit host-owned error not posted");
    a_tx_fifo_post: assert property (tx_err_fifo |-> s_tx_fifo_post)
        else $error("transmit fifo-run error not posted");
    a_tx_stop_fetch: assert property (tx_err |=> tx_susp_o && !tx_ready_o)
        else $error("transmit fetch continues after error");
    a_tx_no_wb: assert property (tx_susp_o |-> !tx_wb_en_o)
        else $error("status write-back permitted while suspended");
    a_tx_idle_code: assert property ((tx_susp_o && sfall && tx_cnt_r == cduo_pkg::BIT_NONE)
        |=> txd_o == cduo_pkg::IDLE_CODE[cduo_pkg::BYTE_MSB])
        else $error("idle code not sent while suspended");
    a_tx_hold_susp: assert property ((tx_susp_o && !tx_react_i) |=> tx_susp_o)
        else $error("transmit left suspension without reactivation");
    a_rx_err_post: assert property (rx_err_fifo |-> ##[2:3] (intd_valid_o && !intd_dir_o
        && intd_err_o == cduo_pkg::ERR_FIFO_RUN))
        else $error("receive fifo-run error not posted");
    a_rx_host_post: assert property (rx_err_host |-> ##[2:3] (intd_valid_o && !intd_dir_o
        && intd_err_o == cduo_pkg::ERR_HOST_OWNED))
        else $error("receive host-owned error not posted");
    a_rx_discard: assert property (rx_err |=> rxf.empty && !rx_valid_o && rx_susp_o)
        else $error("receive data kept after overflow");
    a_rx_no_bus: assert property (rx_susp_o |-> !rx_valid_o)
        else $error("receive bus activity while suspended");
    a_rx_resume: assert property ((rx_susp_o && rx_react && !rx_err) |=> !rx_susp_o)
        else $error("receive reactivation ignored");
    a_no_repeat: assert property ((tx_susp_o |-> !tx_err) and (rx_susp_o |-> !rx_err))
        else $error("error detected again while suspended");

endmodule

//--- cduo_pkg.sv
/*
 * Shared constants for the channel DMA underflow/overflow handler:
 * error codes, direction flags, idle pattern and serial byte timing.
 * Assumes every user refers to these names through cduo_pkg::.
 */
package cduo_pkg;

    // ------------------------------------------------------------
    // Interrupt descriptor fields
    // ------------------------------------------------------------
    localparam logic [1:0] ERR_NONE = 2'h0;
    localparam logic [1:0] ERR_HOST_OWNED = 2'h1; // host_owned_buffer_error
    localparam logic [1:0] ERR_FIFO_RUN = 2'h2;   // fifo_run_error
    localparam logic DIR_TX = 1'h1;
    localparam logic DIR_RX = 1'h0;

    // ------------------------------------------------------------
    // Serial byte framing
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int BYTE_MSB = 7;
    localparam logic [7:0] IDLE_CODE = 8'hff;
    localparam logic [2:0] BIT_NONE = 3'h0;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_STEP = 3'h1;

    // ------------------------------------------------------------
    // Internal FIFO sizing and synchronised pin count
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam int PIN_COUNT = 2;

endpackage

//--- cduo_fifo_if.sv
/*
 * Signal bundle between the handler and one of its internal FIFOs.
 * Assumes the FIFO and its owner share one clock.
 */
`timescale 1ns/1ps

interface cduo_fifo_if #(parameter int W = 8);
    logic push;
    logic pop;
    logic flush;
    logic [W-1:0] wdata;
    logic [W-1:0] rdata;
    logic full;
    logic afull;
    logic empty;

    modport ctrl(output push, output pop, output flush, output wdata,
                 input rdata, input full, input afull, input empty);
    modport store(input push, input pop, input flush, input wdata,
                  output rdata, output full, output afull, output empty);
endinterface

//--- cduo_sync.sv
/*
 * Two-flop synchronisers for pins from outside the mclk domain.
 * Assumes the inputs are levels that last several mclk periods.
 */
`timescale 1ns/1ps

module cduo_sync #(parameter int W = 1)
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // ------------------------------------------------------------
    // One two-stage chain per bit
    // ------------------------------------------------------------
    for (genvar g = 0; g < W; g++)
    begin : g_bit
        logic s1_r;
        logic s2_r;
        // First stage feeds only the second
        always_ff @(posedge mclk_i)
        begin
            if (!resetn_i)
            begin
                s1_r <= 1'h0;
                s2_r <= 1'h0;
            end
            else
            begin
                s1_r <= d_i[g];
                s2_r <= s1_r;
            end
        end
        assign q_o[g] = s2_r;
    end

endmodule

//--- cduo_fifo.sv
/*
 * Small synchronous FIFO with registered look-ahead read data.
 * Assumes the owner never pushes when full; flush beats pop and push.
 */
`timescale 1ns/1ps

module cduo_fifo #(parameter int W = 8, parameter int DEPTH = 16)
(
    input wire logic mclk_i,
    input wire logic resetn_i,
    cduo_fifo_if.store f
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] ONE = (AW+1)'(1);
    localparam logic [AW:0] AFULL_LVL = (AW+1)'(DEPTH - 1);

    // ------------------------------------------------------------
    // Elaboration check: depth must be a power of two, at least 2
    // ------------------------------------------------------------
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
        $error("cduo_fifo depth must be a power of two of at least 2");
    end

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_r;
    logic [AW:0] wr_nxt;
    logic [AW:0] rd_r;
    logic [AW:0] rd_nxt;
    logic [W-1:0] rdata_r;
    logic [W-1:0] rdata_nxt;
    logic push_ok;
    logic pop_ok;

    assign f.empty = (wr_r == rd_r);
    assign f.full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    assign f.afull = ((wr_r - rd_r) >= AFULL_LVL);
    assign f.rdata = rdata_r;

    // Pointer and head-of-queue next values
    always_comb
    begin
        push_ok = f.push && !f.full && !f.flush;
        pop_ok = f.pop && !f.empty && !f.flush;
        wr_nxt = push_ok ? wr_r + ONE : wr_r;
        rd_nxt = f.flush ? wr_r : (pop_ok ? rd_r + ONE : rd_r);
        if (push_ok && wr_r[AW-1:0] == rd_nxt[AW-1:0])
            rdata_nxt = f.wdata; // Write into the slot about to be head
        else
            rdata_nxt = mem[rd_nxt[AW-1:0]];
    end

    // Pointer and read-data registers
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            wr_r <= '0;
            rd_r <= '0;
            rdata_r <= '0;
        end
        else
        begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Storage array, no reset
    always_ff @(posedge mclk_i)
    begin
        if (push_ok)
            mem[wr_r[AW-1:0]] <= f.wdata;
    end

endmodule

//--- cduo_link_model.sv
/*
 * Serial link partner: makes the link clock only inside frames, sends
 * one receive byte MSB first and captures one transmit byte per frame.
 * Assumes the handler shifts txd on link clock falls, samples rxd on rises.
 */
`timescale 1ns/1ps

module cduo_link_model
(
    output logic sclk_o,
    output logic rxd_o,
    input wire logic txd_i
);
    // Link clock stands low between frames
    initial
    begin
        sclk_o = 1'h0;
        rxd_o = 1'h0;
    end

    // One frame of eight 800 ns bit periods; bit 0 of tx is read after the last fall
    task automatic frame(input logic [7:0] rb, output logic [7:0] tb);
        for (int i = 0; i < 8; i++)
        begin
            rxd_o = rb[7-i];
            #400 sclk_o = 1'h1;
            #390;
            if (i > 0)
                tb[8-i] = txd_i;
            #10 sclk_o = 1'h0;
        end
        #790 tb[0] = txd_i;
        #10 rxd_o = ~rb[0]; // Released line shows the inverse of the last bit
    endtask
endmodule

//--- tb_top.sv
/*
 * Self-checking bench for cduo_top: fetch, reactivation and link traffic,
 * with queued expectations for descriptors and received bytes.
 * Assumes cduo_pkg, cduo_top and cduo_link_model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top;
    logic mclk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic sclk_i, rxd_i, txd_o, tx_ready_o, tx_wb_en_o, tx_susp_o;
    logic rx_valid_o, rx_susp_o, intd_valid_o, intd_dir_o;
    logic [7:0] rx_data_o;
    logic [1:0] intd_err_o;
    logic transparent_i = 1'h0;
    logic [7:0] tx_data_i = 8'h00;
    logic tx_valid_i = 1'h0;
    logic tx_buf_owned_i = 1'h0;
    logic tx_react_i = 1'h0;
    logic rx_ready_i = 1'h1;
    logic rx_buf_owned_i = 1'h1;
    logic [2:0] rx_req = 3'h0;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
    logic [2:0] desc_q[$];
    logic [7:0] rxq[$];
    logic [2:0] exp_d;
    logic [8:0] exp_r;
    logic [7:0] got;
    logic [7:0] b[3];

    cduo_top #(.TX_DEPTH(4), .RX_DEPTH(4)) uut (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .sclk_i(sclk_i), .rxd_i(rxd_i), .txd_o(txd_o), .transparent_i(transparent_i),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .tx_buf_owned_i(tx_buf_owned_i), .tx_react_i(tx_react_i), .tx_wb_en_o(tx_wb_en_o),
        .tx_susp_o(tx_susp_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
        .rx_ready_i(rx_ready_i), .rx_buf_owned_i(rx_buf_owned_i), .rx_act_i(rx_req[0]),
        .rx_jump_i(rx_req[1]), .rx_cfg_wr_i(rx_req[2]), .rx_susp_o(rx_susp_o),
        .intd_valid_o(intd_valid_o), .intd_err_o(intd_err_o), .intd_dir_o(intd_dir_o));
    cduo_link_model link (.sclk_o(sclk_i), .rxd_o(rxd_i), .txd_i(txd_o));

    // 10 MHz system clock
    always #50 mclk_i = ~mclk_i;

    // -----------------------------------------------------------
    // Closing report
    // -----------------------------------------------------------
    task automatic results;
        $display("errors=%0d checks=%0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watcher: descriptors and taken bytes against the oldest notes; timeout
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (resetn_i && intd_valid_o)
        begin
            exp_d = (desc_q.size() > 0) ? desc_q.pop_front() : 3'h0;
            `CHK({intd_err_o, intd_dir_o}, exp_d)
        end
        if (resetn_i && rx_valid_o && rx_ready_i)
        begin
            exp_r = (rxq.size() > 0) ? {1'h1, rxq.pop_front()} : 9'h000;
            `CHK({1'h1, rx_data_o}, exp_r)
        end
        if (cyc > 6000)
        begin
            error_cnt++;
            results();
        end
    end

    // -----------------------------------------------------------
    // Drivers
    // -----------------------------------------------------------
    task automatic fetch(input logic [7:0] d);
        int k;
        @(negedge mclk_i);
        tx_data_i = d;
        tx_valid_i = 1'h1;
        k = 0;
        while (tx_ready_o !== 1'h1 && k < 40)
        begin
            @(negedge mclk_i);
            k++;
        end
        `CHK(tx_ready_o, 1'h1)
        @(negedge mclk_i);
        tx_valid_i = 1'h0;
    endtask

    task automatic xfer(input logic [7:0] rb, input logic keep, output logic [7:0] tb);
        if (keep)
            rxq.push_back(rb);
        link.frame(rb, tb);
        repeat (8) @(negedge mclk_i);
    endtask

    // Pulses one request: 0..2 receive triggers, 3 transmit reactivation
    task automatic pulse(input int k);
        @(negedge mclk_i);
        if (k == 3)
            tx_react_i = 1'h1;
        else
            rx_req[k] = 1'h1;
        @(negedge mclk_i);
        tx_react_i = 1'h0;
        rx_req = 3'h0;
        @(negedge mclk_i);
    endtask

    // Main sequence
    initial
    begin
        n = $urandom(32'hfc0971c5);
        repeat (2) @(negedge mclk_i);
        `CHK({txd_o, tx_wb_en_o, tx_susp_o, rx_susp_o, intd_valid_o, rx_valid_o}, 6'h30)
        resetn_i = 1'h1;
        // Transmit under-run while a buffer is owned
        tx_buf_owned_i = 1'h1;
        for (int i = 0; i < 3; i++)
            b[i] = 8'($urandom);
        fetch(b[0]);
        fetch(b[1]);
        for (int i = 0; i < 2; i++)
        begin
            xfer(8'($urandom), 1'h1, got);
            `CHK(got, b[i])
        end
        desc_q.push_back({cduo_pkg::ERR_FIFO_RUN, cduo_pkg::DIR_TX});
        xfer(8'($urandom), 1'h1, got);
        `CHK(got, cduo_pkg::IDLE_CODE)
        `CHK({tx_susp_o, tx_wb_en_o, tx_ready_o}, 3'h4)
        xfer(8'($urandom), 1'h1, got);
        `CHK({got, tx_susp_o, tx_ready_o}, {cduo_pkg::IDLE_CODE, 2'h2})
        // Host-owned next buffer after data was sent
        pulse(3);
        `CHK(tx_susp_o, 1'h0)
        tx_buf_owned_i = 1'h0;
        fetch(b[2]);
        xfer(8'($urandom), 1'h1, got);
        `CHK(got, b[2])
        desc_q.push_back({cduo_pkg::ERR_HOST_OWNED, cduo_pkg::DIR_TX});
        xfer(8'($urandom), 1'h1, got);
        `CHK({got, tx_susp_o, tx_wb_en_o}, {cduo_pkg::IDLE_CODE, 2'h2})
        // Transparent mode with nothing to send
        transparent_i = 1'h1;
        pulse(3);
        desc_q.push_back({cduo_pkg::ERR_HOST_OWNED, cduo_pkg::DIR_TX});
        xfer(8'($urandom), 1'h1, got);
        `CHK({got, tx_susp_o}, {cduo_pkg::IDLE_CODE, 1'h1})
        transparent_i = 1'h0;
        pulse(3);
        // Receive overflow, once per reactivation trigger
        rx_ready_i = 1'h0;
        for (int k = 0; k < 3; k++)
        begin
            rx_buf_owned_i = (k != 1);
            desc_q.push_back({(k != 1) ? cduo_pkg::ERR_FIFO_RUN : cduo_pkg::ERR_HOST_OWNED,
                cduo_pkg::DIR_RX});
            n = 0;
            while (rx_susp_o !== 1'h1 && n < 10)
            begin
                xfer(8'($urandom), 1'h0, got);
                n++;
            end
            `CHK({rx_susp_o, rx_valid_o}, 2'h2)
            xfer(8'($urandom), 1'h0, got);
            `CHK({rx_susp_o, rx_valid_o}, 2'h2)
            pulse(k);
            `CHK(rx_susp_o, 1'h0)
        end
        // Normal reception after recovery
        rx_ready_i = 1'h1;
        rx_buf_owned_i = 1'h1;
        for (int i = 0; i < 3; i++)
            xfer(8'($urandom), 1'h1, got);
        `CHK(rxq.size() + desc_q.size(), 0)
        results();
    end
endmodule
